// ===== srr_defs.svh
// constants for the result readout and shadow block: map, resets, timing
// assumes one include per compile unit; values shared by both link ends
`ifndef SRR_DEFS_SVH
`define SRR_DEFS_SVH

// ----------------------------------------
// result map
// ----------------------------------------
`define SRR_RES_FIRST 8'hF7
`define SRR_RES_LAST_PT 8'hFC
`define SRR_RES_LAST_H 8'hFE
`define SRR_PRESS_RST 20'h80000
`define SRR_TEMP_RST 20'h80000
`define SRR_HUM_RST 16'h8000

// ----------------------------------------
// trim map
// ----------------------------------------
`define SRR_TRIM_A_FIRST 8'h88
`define SRR_TRIM_A_LAST 8'hA1
`define SRR_TRIM_B_FIRST 8'hE1
`define SRR_TRIM_B_LAST 8'hE7
`define SRR_TRIM_A_LEN 6'h1A
`define SRR_TRIM_B_LEN 6'h07
`define SRR_T1 8'h88
`define SRR_T2 8'h8A
`define SRR_T3 8'h8C
`define SRR_P1 8'h8E
`define SRR_P2 8'h90
`define SRR_P3 8'h92
`define SRR_P4 8'h94
`define SRR_P5 8'h96
`define SRR_P6 8'h98
`define SRR_P7 8'h9A
`define SRR_P8 8'h9C
`define SRR_P9 8'h9E
`define SRR_H4 8'hE4
`define SRR_H45 8'hE5
`define SRR_H5 8'hE6

// ----------------------------------------
// timing and arithmetic
// ----------------------------------------
`define SRR_LK_HALF 4'h2
`define SRR_SEL_GAP 5'h10
`define SRR_T_MUL 64'sh5
`define SRR_T_ROUND 64'sh80
`define SRR_P_T_OFS 64'sh1F400
`define SRR_P_BASE 64'sh100000
`define SRR_P_MUL 64'shC35
`define SRR_P_ONE47 64'sh800000000000

`endif

// ===== srr_pkg.sv
// types shared by both link ends of the result readout block
// assumes srr_defs.svh is not needed here: types only
package srr_pkg;

    typedef logic [7:0] srr_byte_t;

    typedef enum logic [2:0] {
        SRR_IDLE,
        SRR_OPEN,
        SRR_WAIT_ACK,
        SRR_WAIT_REL,
        SRR_CLOSE
    } srr_host_st_e;

endpackage

// ===== srr_link_if.sv
// link between host end and sensor end: select frame plus req/ack per byte
// assumes the host drives lk_clk free-running from its own divider
`timescale 1ns/10ps
interface srr_link_if;
    logic lk_clk;
    logic sel_n;
    logic req;
    logic [7:0] addr;
    logic ack;
    logic [7:0] rdata;

    modport host (output lk_clk, output sel_n, output req, output addr,
                  input ack, input rdata);
    modport dev (input lk_clk, input sel_n, input req, input addr,
                 output ack, output rdata);
endinterface // srr_link_if

// ===== srr_sensor_end.sv
// sensor end: result registers, shadow copy, trim storage, link responder
// assumes the host frames bursts with sel_n and requests bytes by 4-phase req/ack
`timescale 1ns/10ps
`include "srr_defs.svh"
module srr_sensor_end #(
    parameter logic [263:0] TRIM_NVM = '0 // factory content, arbitrary default
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic CONV_DONE,
    input wire logic [19:0] CONV_PRESS,
    input wire logic [19:0] CONV_TEMP,
    input wire logic [15:0] CONV_HUM,
    output logic CONV_READY,
    srr_link_if.dev LINK
);

    // ----------------------------------------
    // state types
    // ----------------------------------------
    typedef struct packed {
        logic [19:0] hold_p;
        logic [19:0] hold_t;
        logic [15:0] hold_h;
        logic tog;
        logic busy;
        logic ack_s1;
        logic ack_s2;
        logic ack_d;
    } srr_ref_s;

    typedef struct packed {
        logic sel_s1;
        logic sel_s2;
        logic sel_d;
        logic req_s1;
        logic req_s2;
        logic [7:0] addr_s1;
        logic [7:0] addr_s2;
        logic tog_s1;
        logic tog_s2;
        logic tog_d;
        logic [7:0] ptr;
        logic first;
        logic loaded;
        logic ack;
        logic [7:0] rdata;
        logic touched;
        logic pend;
        logic ack_tog;
        logic [19:0] press;
        logic [19:0] temp;
        logic [15:0] hum;
        logic [19:0] sh_press;
        logic [19:0] sh_temp;
        logic [15:0] sh_hum;
    } srr_lk_s;

    srr_ref_s r_ff;
    srr_ref_s nxt_r;
    srr_lk_s l_ff;
    srr_lk_s nxt_l;

    // reset and enable brought into the link domain
    logic rst_s1_ff;
    logic rst_s2_ff;
    logic ce_s1_ff;
    logic ce_s2_ff;

    // ----------------------------------------
    // byte read decode
    // ----------------------------------------
    function automatic srr_pkg::srr_byte_t rd_byte(input logic [7:0] a, input srr_lk_s s);
        logic [7:0] i;
        i = 8'h00;
        rd_byte = 8'h00;
        if (a >= `SRR_TRIM_A_FIRST && a <= `SRR_TRIM_A_LAST) begin
            i = a - `SRR_TRIM_A_FIRST;
            rd_byte = TRIM_NVM[i*8 +: 8];
        end else if (a >= `SRR_TRIM_B_FIRST && a <= `SRR_TRIM_B_LAST) begin
            i = a - `SRR_TRIM_B_FIRST + 8'(`SRR_TRIM_A_LEN);
            rd_byte = TRIM_NVM[i*8 +: 8];
        end else begin
            case (a)
                8'hF7: rd_byte = s.press[19:12];
                8'hF8: rd_byte = s.press[11:4];
                8'hF9: rd_byte = {s.press[3:0], 4'h0};
                8'hFA: rd_byte = s.temp[19:12];
                8'hFB: rd_byte = s.temp[11:4];
                8'hFC: rd_byte = {s.temp[3:0], 4'h0};
                8'hFD: rd_byte = s.hum[15:8];
                8'hFE: rd_byte = s.hum[7:0];
                default: rd_byte = 8'h00;
            endcase
        end
    endfunction

    // ----------------------------------------
    // conversion side (REF_CLK)
    // ----------------------------------------
    // holding words stay put until the link side acknowledges them,
    // so a new result waits on CONV_READY instead of tearing the copy
    always_comb begin
        nxt_r = r_ff;
        nxt_r.ack_s1 = l_ff.ack_tog;
        nxt_r.ack_s2 = r_ff.ack_s1;
        nxt_r.ack_d = r_ff.ack_s2;
        if (r_ff.ack_s2 != r_ff.ack_d) begin
            nxt_r.busy = 1'b0;
        end
        if (CONV_DONE && !r_ff.busy) begin
            nxt_r.hold_p = CONV_PRESS;
            nxt_r.hold_t = CONV_TEMP;
            nxt_r.hold_h = CONV_HUM;
            nxt_r.tog = ~r_ff.tog;
            nxt_r.busy = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            r_ff <= '0;
        end else if (CE) begin
            r_ff <= nxt_r;
        end
    end

    assign CONV_READY = !r_ff.busy;

    // ----------------------------------------
    // link side synchronisers
    // ----------------------------------------
    always_ff @(posedge LINK.lk_clk) begin
        rst_s1_ff <= RESETN;
        rst_s2_ff <= rst_s1_ff;
        ce_s1_ff <= CE;
        ce_s2_ff <= ce_s1_ff;
    end

    // ----------------------------------------
    // link side: frame, reads, shadowing
    // ----------------------------------------
    always_comb begin
        logic conv;
        logic burst_end;
        logic [7:0] a;
        conv = 1'b0;
        burst_end = 1'b0;
        a = 8'h00;
        nxt_l = l_ff;
        nxt_l.sel_s1 = LINK.sel_n;
        nxt_l.sel_s2 = l_ff.sel_s1;
        nxt_l.sel_d = l_ff.sel_s2;
        nxt_l.req_s1 = LINK.req;
        nxt_l.req_s2 = l_ff.req_s1;
        nxt_l.addr_s1 = LINK.addr;
        nxt_l.addr_s2 = l_ff.addr_s1;
        nxt_l.tog_s1 = r_ff.tog;
        nxt_l.tog_s2 = l_ff.tog_s1;
        nxt_l.tog_d = l_ff.tog_s2;
        conv = l_ff.tog_s2 != l_ff.tog_d;
        burst_end = l_ff.sel_s2 && !l_ff.sel_d;

        if (conv) begin
            nxt_l.ack_tog = ~l_ff.ack_tog;
            if (l_ff.touched && !burst_end) begin
                nxt_l.sh_press = r_ff.hold_p;
                nxt_l.sh_temp = r_ff.hold_t;
                nxt_l.sh_hum = r_ff.hold_h;
                nxt_l.pend = 1'b1;
            end else begin
                // newest conversion wins; any older shadow is stale now
                nxt_l.press = r_ff.hold_p;
                nxt_l.temp = r_ff.hold_t;
                nxt_l.hum = r_ff.hold_h;
                nxt_l.pend = 1'b0;
            end
        end else if (burst_end && l_ff.pend) begin
            nxt_l.press = l_ff.sh_press;
            nxt_l.temp = l_ff.sh_temp;
            nxt_l.hum = l_ff.sh_hum;
            nxt_l.pend = 1'b0;
        end
        // without pend nothing moves at the end of a burst, unless a conversion lands in that same cycle

        // protection spans one frame only; a new frame starts clean
        if (l_ff.sel_s2) begin
            nxt_l.first = 1'b1;
            nxt_l.touched = 1'b0;
        end

        if (!l_ff.sel_s2 && l_ff.req_s2 && !l_ff.loaded) begin
            a = l_ff.first ? l_ff.addr_s2 : l_ff.ptr;
            nxt_l.rdata = rd_byte(a, l_ff);
            nxt_l.ptr = a + 8'h01;
            nxt_l.first = 1'b0;
            nxt_l.loaded = 1'b1;
            if (a >= `SRR_RES_FIRST && a <= `SRR_RES_LAST_H) begin
                nxt_l.touched = 1'b1;
            end
        end
        if (!l_ff.req_s2) begin
            nxt_l.loaded = 1'b0;
        end
        // ack one cycle behind the data so the data has settled before ack crosses
        nxt_l.ack = l_ff.loaded && l_ff.req_s2;
    end

    always_ff @(posedge LINK.lk_clk) begin
        if (!rst_s2_ff) begin
            l_ff <= '0;
            l_ff.sel_s1 <= 1'b1;
            l_ff.sel_s2 <= 1'b1;
            l_ff.sel_d <= 1'b1;
            l_ff.first <= 1'b1;
            l_ff.press <= `SRR_PRESS_RST;
            l_ff.temp <= `SRR_TEMP_RST;
            l_ff.hum <= `SRR_HUM_RST;
            l_ff.sh_press <= `SRR_PRESS_RST;
            l_ff.sh_temp <= `SRR_TEMP_RST;
            l_ff.sh_hum <= `SRR_HUM_RST;
        end else if (ce_s2_ff) begin
            l_ff <= nxt_l;
        end
    end

    assign LINK.ack = l_ff.ack;
    assign LINK.rdata = l_ff.rdata;

endmodule // srr_sensor_end

// ===== srr_host_end.sv
// host end: link clock divider, burst reader, trim assembly, compensation
// assumes fine temperature is supplied by the user on REF_CLK
`timescale 1ns/10ps
`include "srr_defs.svh"
module srr_host_end (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic START_RES,
    input wire logic HUM_EN,
    input wire logic START_TRIM,
    input wire logic signed [31:0] T_FINE,
    output logic BUSY,
    output logic DONE,
    output logic [19:0] RAW_PRESS,
    output logic [19:0] RAW_TEMP,
    output logic [15:0] RAW_HUM,
    output logic [11:0] HUM_TRIM4,
    output logic [11:0] HUM_TRIM5,
    output logic signed [31:0] TEMP_CDEG,
    output logic signed [63:0] PRESS_PRE,
    output logic PRESS_DIV0,
    srr_link_if.host LINK
);

    typedef struct packed {
        logic [3:0] div;
        logic lk;
        srr_pkg::srr_host_st_e st;
        logic sel_n;
        logic req;
        logic [7:0] addr;
        logic ack_s1;
        logic ack_s2;
        logic [7:0] dat_s1;
        logic [7:0] dat_s2;
        logic [4:0] gap;
        logic [5:0] idx;
        logic job;
        logic seg;
        logic hum_en;
        logic done;
        logic [7:0][7:0] res;
        logic [32:0][7:0] trm;
        logic signed [31:0] temp_c;
        logic signed [63:0] p_pre;
        logic div0;
    } srr_host_s;

    srr_host_s s_ff;
    srr_host_s nxt_s;

    // ----------------------------------------
    // trim helpers
    // ----------------------------------------
    function automatic logic [5:0] tidx(input logic [7:0] a);
        logic [7:0] i;
        i = (a <= `SRR_TRIM_A_LAST) ? a - `SRR_TRIM_A_FIRST
                                    : a - `SRR_TRIM_B_FIRST + 8'(`SRR_TRIM_A_LEN);
        tidx = i[5:0];
    endfunction

    function automatic logic signed [63:0] tw(input logic [7:0] a, input logic sgn,
                                              input logic [32:0][7:0] t);
        logic [15:0] w;
        w = {t[tidx(a) + 6'h01], t[tidx(a)]};
        tw = sgn ? 64'(signed'(w)) : 64'(w);
    endfunction

    // ----------------------------------------
    // burst sequencer and compensation
    // ----------------------------------------
    always_comb begin
        logic [5:0] last;
        logic signed [63:0] v1;
        logic signed [63:0] v2;
        logic signed [63:0] p;
        last = 6'h00;
        v1 = '0;
        v2 = '0;
        p = '0;
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        nxt_s.ack_s1 = LINK.ack;
        nxt_s.ack_s2 = s_ff.ack_s1;
        nxt_s.dat_s1 = LINK.rdata;
        nxt_s.dat_s2 = s_ff.dat_s1;
        nxt_s.div = s_ff.div + 4'h1;
        if (s_ff.div == `SRR_LK_HALF - 4'h1) begin
            nxt_s.div = 4'h0;
            nxt_s.lk = ~s_ff.lk;
        end
        if (s_ff.job) begin
            last = s_ff.seg ? `SRR_TRIM_B_LEN - 6'h01 : `SRR_TRIM_A_LEN - 6'h01;
        end else begin
            last = s_ff.hum_en ? 6'h07 : 6'h05;
        end

        case (s_ff.st)
            srr_pkg::SRR_IDLE: begin
                nxt_s.idx = 6'h00;
                nxt_s.gap = `SRR_SEL_GAP;
                if (START_RES) begin
                    nxt_s.job = 1'b0;
                    nxt_s.hum_en = HUM_EN;
                    nxt_s.addr = `SRR_RES_FIRST;
                    nxt_s.sel_n = 1'b0;
                    nxt_s.st = srr_pkg::SRR_OPEN;
                end else if (START_TRIM) begin
                    nxt_s.job = 1'b1;
                    nxt_s.seg = 1'b0;
                    nxt_s.addr = `SRR_TRIM_A_FIRST;
                    nxt_s.sel_n = 1'b0;
                    nxt_s.st = srr_pkg::SRR_OPEN;
                end
            end
            srr_pkg::SRR_OPEN: begin
                nxt_s.gap = s_ff.gap - 5'h01;
                if (s_ff.gap == 5'h00) begin
                    nxt_s.req = 1'b1;
                    nxt_s.st = srr_pkg::SRR_WAIT_ACK;
                end
            end
            srr_pkg::SRR_WAIT_ACK: begin
                if (s_ff.ack_s2) begin
                    if (s_ff.job) begin
                        nxt_s.trm[s_ff.seg ? s_ff.idx + `SRR_TRIM_A_LEN : s_ff.idx] = s_ff.dat_s2;
                    end else begin
                        nxt_s.res[s_ff.idx[2:0]] = s_ff.dat_s2;
                    end
                    nxt_s.req = 1'b0;
                    nxt_s.st = srr_pkg::SRR_WAIT_REL;
                end
            end
            srr_pkg::SRR_WAIT_REL: begin
                if (!s_ff.ack_s2) begin
                    if (s_ff.idx == last) begin
                        nxt_s.sel_n = 1'b1;
                        nxt_s.gap = `SRR_SEL_GAP;
                        nxt_s.st = srr_pkg::SRR_CLOSE;
                    end else begin
                        nxt_s.idx = s_ff.idx + 6'h01;
                        nxt_s.req = 1'b1;
                        nxt_s.st = srr_pkg::SRR_WAIT_ACK;
                    end
                end
            end
            srr_pkg::SRR_CLOSE: begin
                // select must stay high long enough for the far end to see it
                nxt_s.gap = s_ff.gap - 5'h01;
                if (s_ff.gap == 5'h00) begin
                    if (s_ff.job && !s_ff.seg) begin
                        nxt_s.seg = 1'b1;
                        nxt_s.idx = 6'h00;
                        nxt_s.addr = `SRR_TRIM_B_FIRST;
                        nxt_s.sel_n = 1'b0;
                        nxt_s.gap = `SRR_SEL_GAP;
                        nxt_s.st = srr_pkg::SRR_OPEN;
                    end else begin
                        nxt_s.done = 1'b1;
                        nxt_s.st = srr_pkg::SRR_IDLE;
                    end
                end
            end
            default: nxt_s.st = srr_pkg::SRR_IDLE;
        endcase

        // only the documented tail is built; earlier/later steps come
        nxt_s.temp_c = 32'((64'(T_FINE) * `SRR_T_MUL + `SRR_T_ROUND) >>> 8);
        v1 = 64'(T_FINE) - `SRR_P_T_OFS;
        v2 = v1 * v1 * tw(`SRR_P6, 1'b1, s_ff.trm);
        v2 = v2 + ((v1 * tw(`SRR_P5, 1'b1, s_ff.trm)) <<< 17);
        v2 = v2 + (tw(`SRR_P4, 1'b1, s_ff.trm) <<< 35);
        v1 = ((v1 * v1 * tw(`SRR_P3, 1'b1, s_ff.trm)) >>> 8)
             + ((v1 * tw(`SRR_P2, 1'b1, s_ff.trm)) <<< 12);
        v1 = ((`SRR_P_ONE47 + v1) * tw(`SRR_P1, 1'b0, s_ff.trm)) >>> 33;
        if (v1 == 64'sh0) begin
            nxt_s.p_pre = 64'sh0;
            nxt_s.div0 = 1'b1;
        end else begin
            p = `SRR_P_BASE - 64'({s_ff.res[0], s_ff.res[1], s_ff.res[2][7:4]});
            nxt_s.p_pre = (((p <<< 31) - v2) * `SRR_P_MUL) / v1;
            nxt_s.div0 = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            s_ff <= '0;
            s_ff.sel_n <= 1'b1;
            s_ff.st <= srr_pkg::SRR_IDLE;
            // divider runs through reset, else the far end's link domain never resets
            if (CE && s_ff.div < `SRR_LK_HALF) begin
                s_ff.div <= nxt_s.div;
                s_ff.lk <= nxt_s.lk;
            end
        end else if (CE) begin
            s_ff <= nxt_s;
        end
    end

    assign LINK.lk_clk = s_ff.lk;
    assign LINK.sel_n = s_ff.sel_n;
    assign LINK.req = s_ff.req;
    assign LINK.addr = s_ff.addr;
    assign BUSY = s_ff.st != srr_pkg::SRR_IDLE;
    assign DONE = s_ff.done;
    assign RAW_PRESS = {s_ff.res[0], s_ff.res[1], s_ff.res[2][7:4]};
    assign RAW_TEMP = {s_ff.res[3], s_ff.res[4], s_ff.res[5][7:4]};
    assign RAW_HUM = {s_ff.res[6], s_ff.res[7]};
    assign HUM_TRIM4 = {s_ff.trm[tidx(`SRR_H4)], s_ff.trm[tidx(`SRR_H45)][3:0]};
    assign HUM_TRIM5 = {s_ff.trm[tidx(`SRR_H5)], s_ff.trm[tidx(`SRR_H45)][7:4]};
    assign TEMP_CDEG = s_ff.temp_c;
    assign PRESS_PRE = s_ff.p_pre;
    assign PRESS_DIV0 = s_ff.div0;

endmodule // srr_host_end

// ===== srr_link_sva.sv
// link checker: framing, handshake and data holding between the two ends
// assumes the host's lk_clk divider runs on REF_CLK, so all link signals are sampled there
`timescale 1ns/10ps
module srr_link_sva (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic lk_clk,
    input wire logic sel_n,
    input wire logic req,
    input wire logic [7:0] addr,
    input wire logic ack,
    input wire logic [7:0] rdata
);
    // ----------------------------------------
    // clocking and sequences
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);

    // two runs of eight: unrolled repetition kept short
    sequence s_quiet_req;
        (!req) [*8] ##1 (!req) [*8];
    endsequence
    sequence s_sel_gap;
        sel_n [*8] ##1 sel_n [*8];
    endsequence

    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_req_framed;
        req |-> !sel_n;
    endproperty
    property p_ack_cause;
        $rose(ack) |-> req && !sel_n;
    endproperty
    property p_data_stands;
        ack && $past(ack) |-> $stable(rdata);
    endproperty
    property p_req_holds;
        req && !ack |=> req;
    endproperty
    property p_req_waits;
        !req && ack |=> !req;
    endproperty
    property p_ack_drops;
        $fell(req) |-> ##[1:40] !ack;
    endproperty
    property p_req_drops;
        $rose(ack) |-> ##[1:40] !req;
    endproperty
    property p_first_gap;
        $fell(sel_n) |-> s_quiet_req;
    endproperty
    property p_frame_gap;
        $rose(sel_n) |-> s_sel_gap;
    endproperty
    property p_start_addr;
        $fell(sel_n) |-> (addr == 8'hF7 || addr == 8'h88 || addr == 8'hE1);
    endproperty
    property p_lk_div;
        $changed(lk_clk) |=> $stable(lk_clk) ##1 $changed(lk_clk);
    endproperty

    a_req_framed: assert property (p_req_framed)
        else $error("byte request outside a select frame");
    a_ack_cause: assert property (p_ack_cause)
        else $error("acknowledge without a pending request");
    a_data_stands: assert property (p_data_stands)
        else $error("read data changed while acknowledged");
    a_req_holds: assert property (p_req_holds)
        else $error("request dropped before acknowledge");
    a_req_waits: assert property (p_req_waits)
        else $error("new request before acknowledge fell");
    a_ack_drops: assert property (p_ack_drops)
        else $error("acknowledge stuck after request fell");
    a_req_drops: assert property (p_req_drops)
        else $error("request stuck after acknowledge");
    a_first_gap: assert property (p_first_gap)
        else $error("request too soon after select fell");
    a_frame_gap: assert property (p_frame_gap)
        else $error("frames too close together");
    a_start_addr: assert property (p_start_addr)
        else $error("burst starts at an unexpected address");
    a_lk_div: assert property (p_lk_div)
        else $error("link clock not divided by four");
endmodule // srr_link_sva

// ===== sensor_result_readout_shadow_test.sv
// bench for the result readout block: host end and sensor end joined by the link
// assumes CE held high; lk_clk comes from the host's own divider
`timescale 1ns/10ps
`include "srr_defs.svh"
module sensor_result_readout_shadow_test;
    function automatic logic [263:0] mk_trim();
        logic [263:0] v;
        v = '0;
        for (int k = 0; k < 33; k++) begin
            v[8*k+:8] = 8'(8'h10 + k);
        end
        return v;
    endfunction
    localparam logic [263:0] TRIM = mk_trim();

    // pressure trim word k, low address as low byte
    function automatic logic signed [63:0] pw(input int k);
        return 64'(TRIM[8*(4+2*k)+:16]);
    endfunction

    // pressure up to the division step, straight from the compensation rules
    function automatic logic signed [63:0] exp_press(input logic signed [31:0] tf,
                                                      input logic [19:0] adc);
        logic signed [63:0] a, b, p;
        a = 64'(tf) - `SRR_P_T_OFS;
        b = a * a * pw(6);
        b = b + ((a * pw(5)) <<< 17);
        b = b + (pw(4) <<< 35);
        a = ((a * a * pw(3)) >>> 8) + ((a * pw(2)) <<< 12);
        a = ((`SRR_P_ONE47 + a) * pw(1)) >>> 33;
        if (a == 64'sh0) return 64'sh0;
        p = `SRR_P_BASE - 64'(adc);
        return (((p <<< 31) - b) * `SRR_P_MUL) / a;
    endfunction

    logic ref_clk, resetn, ce, conv_done, conv_ready, start_res, hum_en, start_trim;
    logic busy, done, press_div0;
    logic [19:0] conv_press, conv_temp, raw_press, raw_temp;
    logic [15:0] conv_hum, raw_hum;
    logic [11:0] hum_trim4, hum_trim5;
    logic signed [31:0] t_fine, temp_cdeg;
    logic signed [63:0] press_pre;
    int bad_count, n_tests;

    srr_link_if srr_link_if_i ();
    srr_sensor_end #(.TRIM_NVM(TRIM)) srr_sensor_end_i (.REF_CLK(ref_clk), .RESETN(resetn),
        .CE(ce), .CONV_DONE(conv_done), .CONV_PRESS(conv_press), .CONV_TEMP(conv_temp),
        .CONV_HUM(conv_hum), .CONV_READY(conv_ready), .LINK(srr_link_if_i));
    srr_host_end srr_host_end_i (.REF_CLK(ref_clk), .RESETN(resetn), .CE(ce),
        .START_RES(start_res), .HUM_EN(hum_en), .START_TRIM(start_trim), .T_FINE(t_fine),
        .BUSY(busy), .DONE(done), .RAW_PRESS(raw_press), .RAW_TEMP(raw_temp),
        .RAW_HUM(raw_hum), .HUM_TRIM4(hum_trim4), .HUM_TRIM5(hum_trim5),
        .TEMP_CDEG(temp_cdeg), .PRESS_PRE(press_pre), .PRESS_DIV0(press_div0),
        .LINK(srr_link_if_i));
    srr_link_sva srr_link_sva_i (.REF_CLK(ref_clk), .RESETN(resetn),
        .lk_clk(srr_link_if_i.lk_clk), .sel_n(srr_link_if_i.sel_n), .req(srr_link_if_i.req),
        .addr(srr_link_if_i.addr), .ack(srr_link_if_i.ack), .rdata(srr_link_if_i.rdata));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // 0: done pulse, 1: link acknowledge, 2: conversion input ready
    task automatic wait_hi(input int what);
        for (int i = 0; i < 4000; i++) begin
            @(posedge ref_clk);
            #1;
            if (what == 0 && done === 1'b1) return;
            if (what == 1 && srr_link_if_i.ack === 1'b1) return;
            if (what == 2 && conv_ready === 1'b1) return;
        end
        bad_count++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
        tally_and_finish();
    endtask

    task automatic start(input logic res, input logic hum);
        @(negedge ref_clk);
        start_res = res;
        start_trim = !res;
        hum_en = hum;
        @(negedge ref_clk);
        start_res = 1'b0;
        start_trim = 1'b0;
    endtask

    task automatic convert(input logic [19:0] p, input logic [19:0] t, input logic [15:0] h);
        wait_hi(2);
        @(negedge ref_clk);
        conv_press = p;
        conv_temp = t;
        conv_hum = h;
        conv_done = 1'b1;
        @(negedge ref_clk);
        conv_done = 1'b0;
    endtask

    task automatic read_all(input logic [19:0] p, input logic [19:0] t, input logic [15:0] h);
        wait_hi(2);
        start(1'b1, 1'b1);
        check(64'(busy), 64'(1'b1));
        wait_hi(0);
        check(64'(busy), 64'(1'b0));
        check(64'(raw_press), 64'(p));
        check(64'(raw_temp), 64'(t));
        check(64'(raw_hum), 64'(h));
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_vals();
        read_all(`SRR_PRESS_RST, `SRR_TEMP_RST, `SRR_HUM_RST);
        $display("test reset_vals done");
    endtask

    task automatic t_direct();
        convert(20'hABCDE, 20'h12345, 16'h6789);
        read_all(20'hABCDE, 20'h12345, 16'h6789);
        $display("test direct done");
    endtask

    // conversion lands mid burst; short burst leaves humidity unread
    task automatic t_shadow();
        start(1'b1, 1'b0);
        wait_hi(1);
        convert(20'h54321, 20'h0FEDC, 16'h1357);
        wait_hi(0);
        check(64'(raw_press), 64'(20'hABCDE));
        check(64'(raw_temp), 64'(20'h12345));
        read_all(20'h54321, 20'h0FEDC, 16'h1357);
        $display("test shadow done");
    endtask

    task automatic t_temp();
        logic signed [31:0] vals [4];
        logic signed [63:0] e;
        vals = '{32'sd0, -32'sd1, -32'sd128, 32'sd2000000};
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk);
            t_fine = vals[i];
            @(posedge ref_clk);
            #1;
            e = (64'(vals[i]) * 64'sd5 + 64'sd128) >>> 8;
            check(64'(temp_cdeg), e);
        end
        $display("test temp done");
    endtask

    // trim still cleared from reset: zero divisor first, real value after the load
    task automatic t_trim();
        check(64'(press_div0), 64'(1'b1));
        check(press_pre, 64'h0);
        start(1'b0, 1'b0);
        t_fine = 32'sh1F400;
        wait_hi(0);
        repeat (4) @(posedge ref_clk);
        #1;
        check(64'(hum_trim4), 64'({TRIM[29*8+:8], TRIM[30*8+:4]}));
        check(64'(hum_trim5), 64'({TRIM[31*8+:8], TRIM[30*8+4+:4]}));
        check(64'(press_div0), 64'(1'b0));
        check(press_pre, exp_press(32'sh1F400, 20'h54321));
        $display("test trim done");
    endtask

    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        conv_done = 1'b0;
        conv_press = '0;
        conv_temp = '0;
        conv_hum = '0;
        start_res = 1'b0;
        start_trim = 1'b0;
        hum_en = 1'b0;
        t_fine = '0;
        bad_count = 0;
        n_tests = 0;
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        // device link side leaves reset only after lk_clk has run
        repeat (20) @(negedge ref_clk);
        t_reset_vals();
        t_direct();
        t_shadow();
        t_temp();
        t_trim();
        tally_and_finish();
    end
endmodule // sensor_result_readout_shadow_test
